/* hw/supply_supervisor_consts.vh */
// Purpose: Constants shared by the supply supervisor mode control files.
// Assumes: 40 MHz system clock, 25 ns period.
// Notes: Times are kept in nanoseconds; cycle counts derive from them.
`ifndef SUPPLY_SUPERVISOR_CONSTS_VH
`define SUPPLY_SUPERVISOR_CONSTS_VH

// Clock period in nanoseconds.
`define SSV_CLK_PERIOD_NS 25
// Full performance event masking and settling time in nanoseconds.
`define SSV_FULL_PERF_DELAY_NS 2000
// Normal mode settling and wakeup mask time in nanoseconds.
`define SSV_NORMAL_DELAY_NS 150000
// Cycle counts (least times round up).
`define SSV_FULL_PERF_CYCLES ((`SSV_FULL_PERF_DELAY_NS + `SSV_CLK_PERIOD_NS - 1) / `SSV_CLK_PERIOD_NS)
`define SSV_NORMAL_CYCLES ((`SSV_NORMAL_DELAY_NS + `SSV_CLK_PERIOD_NS - 1) / `SSV_CLK_PERIOD_NS)
// Comparator state encoding.
`define SSV_STATE_OFF 2'h0
`define SSV_STATE_NORMAL 2'h1
`define SSV_STATE_FULL 2'h2
// Power mode encoding from the sequencer.
`define SSV_PM_ACTIVE 3'h0
`define SSV_PM_LPM1 3'h1
`define SSV_PM_LOW_POWER_MODE_2 3'h2
`define SSV_PM_LOW_POWER_MODE_3 3'h3
`define SSV_PM_LOW_POWER_MODE_4 3'h4
// Counter width.
`define SSV_CNT_W 13

`endif

/* hw/comparator_state_select.v */
// Purpose: Picks the operating state of one supervisor or monitor comparator.
// Assumes: Inputs are static configuration and the current power mode.
// Notes: Pure combinational; one instance per comparator.
`timescale 1ns/1ps
`include "supply_supervisor_consts.vh"

module comparator_state_select #(
  parameter IS_SUPERVISOR = 1
) (
  // Configuration.
  input wire enable,
  input wire keep,
  input wire full_perf,
  input wire auto_control,
  // Mode.
  input wire deep_sleep,
  // Result.
  output reg [1:0] state
);

  // Active state follows the full performance select.
  wire [1:0] active_state;
  assign active_state = full_perf ? `SSV_STATE_FULL : `SSV_STATE_NORMAL;

  // Table of states for active, manual deep sleep and automatic deep sleep.
  always @* begin
    state = `SSV_STATE_OFF;
    if (!enable) begin
      state = `SSV_STATE_OFF;
    end else if (!deep_sleep) begin
      state = active_state;
    end else if (IS_SUPERVISOR != 0) begin
      if (!auto_control) begin
        // Keep bit clear drops the comparator on deep sleep entry.
        state = keep ? active_state : `SSV_STATE_OFF;
      end else begin
        state = (keep && full_perf) ? `SSV_STATE_NORMAL : `SSV_STATE_OFF;
      end
    end else begin
      if (!auto_control) begin
        state = active_state;
      end else begin
        state = full_perf ? `SSV_STATE_NORMAL : `SSV_STATE_OFF;
      end
    end
  end

endmodule // comparator_state_select

/* hw/settle_timer.v */
// Purpose: Down counter for a settling or masking delay.
// Assumes: A start pulse loads the count; busy stays high until zero.
// Notes: Restart while running reloads the count.
`timescale 1ns/1ps
`include "supply_supervisor_consts.vh"

module settle_timer #(
  parameter CNT_W = `SSV_CNT_W
) (
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  // Control.
  input wire start,
  input wire [CNT_W-1:0] load_value,
  // Status.
  output wire busy
);

  // Remaining cycles of the delay.
  reg [CNT_W-1:0] count_r;
  reg [CNT_W-1:0] count_nxt;

  // Load on start, otherwise count down to zero.
  always @* begin
    count_nxt = count_r;
    if (start) begin
      count_nxt = load_value;
    end else if (count_r != {CNT_W{1'b0}}) begin
      count_nxt = count_r - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Counter register.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= {CNT_W{1'b0}};
    end else begin
      count_r <= count_nxt;
    end
  end

  assign busy = (count_r != {CNT_W{1'b0}});

endmodule // settle_timer

/* hw/supply_supervisor_mode_control.v */
// Purpose: Mode control of the low side and high side supply supervisors and monitors.
// Assumes: Inputs are synchronous to clk; software sets configuration ports.
// Notes: Analog comparators sit outside; their raw fault levels come in here.
//
// Notes on behaviour
// - Full performance enable masks faults two microseconds.
// - Fault sets flag; reset only if enabled.
// - Flags set: tri-state I/O until settled.
// - Keep clear: supervisor off in deep sleep.
// - Any reset re-enables both supervisors.
// - Normal low side: 150 us wake mask.
// - Low side off or full: 2 us mask.
// - Sub-main clock from oscillator never masked.
// - Normal low supervisor settles about 150 us.
// - Supervisor state table per enable, keep, mode.
// - Monitor state table per enable, mode, control.
// - Normal low side means slow wakeup.
// - High supervisor normal, keep clear: off.
`timescale 1ns/1ps
`include "supply_supervisor_consts.vh"

module supply_supervisor_mode_control #(
  parameter CNT_W = `SSV_CNT_W,
  parameter FULL_CYCLES = `SSV_FULL_PERF_CYCLES,
  parameter NORMAL_CYCLES = `SSV_NORMAL_CYCLES
) (
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  input wire soft_reset,
  // Low side control register fields.
  input wire low_side_control_write,
  input wire low_supervisor_enable_in,
  input wire low_supervisor_keep,
  input wire low_supervisor_full_perf,
  input wire low_monitor_enable,
  input wire low_monitor_full_perf,
  input wire low_side_auto_control,
  input wire low_supervisor_reset_enable,
  // High side control register fields.
  input wire high_side_control_write,
  input wire high_supervisor_enable_in,
  input wire high_supervisor_keep,
  input wire high_supervisor_full_perf,
  input wire high_monitor_enable,
  input wire high_monitor_full_perf,
  input wire high_side_auto_control,
  input wire high_supervisor_reset_enable,
  // Fault flag clears from software.
  input wire low_fault_flag_clear,
  input wire high_fault_flag_clear,
  // Raw comparator faults.
  input wire low_supervisor_fault_raw,
  input wire high_supervisor_fault_raw,
  // Power mode sequencer.
  input wire [2:0] power_mode,
  input wire sub_main_clock_from_osc,
  // Comparator states.
  output wire [1:0] low_supervisor_state,
  output wire [1:0] low_monitor_state,
  output wire [1:0] high_supervisor_state,
  output wire [1:0] high_monitor_state,
  // Status.
  output reg low_supervisor_enable,
  output reg high_supervisor_enable,
  output reg low_supervisor_fault_flag,
  output reg high_supervisor_fault_flag,
  output wire low_settle_pending_flag,
  output wire high_settle_pending_flag,
  output reg power_on_reset_req,
  output wire gpio_hiz,
  output wire slow_wakeup,
  output wire cpu_exec_mask,
  output wire sub_main_clock_mask
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode.

  // Deep sleep covers modes 2, 3 and 4.
  wire deep_sleep;
  assign deep_sleep = (power_mode == `SSV_PM_LOW_POWER_MODE_2) || (power_mode == `SSV_PM_LOW_POWER_MODE_3) ||
    (power_mode == `SSV_PM_LOW_POWER_MODE_4);
  // Modes 3 and 4 carry the CPU wakeup mask.
  wire deep_34;
  assign deep_34 = (power_mode == `SSV_PM_LOW_POWER_MODE_3) || (power_mode == `SSV_PM_LOW_POWER_MODE_4);
  // Previous deep flags for wake edge detection.
  reg deep_sleep_r;
  reg deep_34_r;

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor enables.

  // Both supervisors come up enabled after any reset.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_supervisor_enable <= 1'b1;
      high_supervisor_enable <= 1'b1;
    end else if (soft_reset) begin
      low_supervisor_enable <= 1'b1;
      high_supervisor_enable <= 1'b1;
    end else begin
      if (low_side_control_write) begin
        low_supervisor_enable <= low_supervisor_enable_in;
      end
      if (high_side_control_write) begin
        high_supervisor_enable <= high_supervisor_enable_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State selection.

  comparator_state_select #(.IS_SUPERVISOR(1)) u_low_sup (
    .enable(low_supervisor_enable),
    .keep(low_supervisor_keep),
    .full_perf(low_supervisor_full_perf),
    .auto_control(low_side_auto_control),
    .deep_sleep(deep_sleep),
    .state(low_supervisor_state)
  );

  comparator_state_select #(.IS_SUPERVISOR(0)) u_low_mon (
    .enable(low_monitor_enable),
    .keep(1'b0),
    .full_perf(low_monitor_full_perf),
    .auto_control(low_side_auto_control),
    .deep_sleep(deep_sleep),
    .state(low_monitor_state)
  );

  comparator_state_select #(.IS_SUPERVISOR(1)) u_high_sup (
    .enable(high_supervisor_enable),
    .keep(high_supervisor_keep),
    .full_perf(high_supervisor_full_perf),
    .auto_control(high_side_auto_control),
    .deep_sleep(deep_sleep),
    .state(high_supervisor_state)
  );

  comparator_state_select #(.IS_SUPERVISOR(0)) u_high_mon (
    .enable(high_monitor_enable),
    .keep(1'b0),
    .full_perf(high_monitor_full_perf),
    .auto_control(high_side_auto_control),
    .deep_sleep(deep_sleep),
    .state(high_monitor_state)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Settling and masking delays.

  // Previous supervisor states, to spot a comparator turning on.
  reg [1:0] low_state_r;
  reg [1:0] high_state_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_state_r <= `SSV_STATE_OFF;
      high_state_r <= `SSV_STATE_OFF;
      deep_sleep_r <= 1'b0;
      deep_34_r <= 1'b0;
    end else begin
      low_state_r <= low_supervisor_state;
      high_state_r <= high_supervisor_state;
      deep_sleep_r <= deep_sleep;
      deep_34_r <= deep_34;
    end
  end

  // A supervisor that leaves off needs its own masking delay.
  wire low_turn_on;
  wire high_turn_on;
  assign low_turn_on = (low_state_r == `SSV_STATE_OFF) && (low_supervisor_state != `SSV_STATE_OFF);
  assign high_turn_on = (high_state_r == `SSV_STATE_OFF) && (high_supervisor_state != `SSV_STATE_OFF);

  // Delay length follows the performance mode of the supervisor.
  wire [CNT_W-1:0] low_load;
  wire [CNT_W-1:0] high_load;
  assign low_load = (low_supervisor_state == `SSV_STATE_FULL) ? FULL_CYCLES[CNT_W-1:0] :
    NORMAL_CYCLES[CNT_W-1:0];
  assign high_load = (high_supervisor_state == `SSV_STATE_FULL) ? FULL_CYCLES[CNT_W-1:0] :
    NORMAL_CYCLES[CNT_W-1:0];

  wire low_busy;
  wire high_busy;

  settle_timer #(.CNT_W(CNT_W)) u_low_timer (
    .clk(clk),
    .rst_b(rst_b),
    .start(low_side_control_write | low_turn_on),
    .load_value(low_load),
    .busy(low_busy)
  );

  settle_timer #(.CNT_W(CNT_W)) u_high_timer (
    .clk(clk),
    .rst_b(rst_b),
    .start(high_side_control_write | high_turn_on),
    .load_value(high_load),
    .busy(high_busy)
  );

  // Pending flags show the delay, and rise in the cycle after the write, not in the write cycle itself.
  assign low_settle_pending_flag = low_busy;
  assign high_settle_pending_flag = high_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Fault flags and reset request.

  // Faults count only from a running, settled supervisor.
  wire low_fault_ev;
  wire high_fault_ev;
  assign low_fault_ev = low_supervisor_fault_raw && !low_busy && !low_turn_on &&
    (low_supervisor_state != `SSV_STATE_OFF);
  assign high_fault_ev = high_supervisor_fault_raw && !high_busy && !high_turn_on &&
    (high_supervisor_state != `SSV_STATE_OFF);

  // Set wins over a clear in the same cycle so no event is lost.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_supervisor_fault_flag <= 1'b0;
      high_supervisor_fault_flag <= 1'b0;
      power_on_reset_req <= 1'b0;
    end else begin
      if (low_fault_ev) begin
        low_supervisor_fault_flag <= 1'b1;
      end else if (low_fault_flag_clear) begin
        low_supervisor_fault_flag <= 1'b0;
      end
      if (high_fault_ev) begin
        high_supervisor_fault_flag <= 1'b1;
      end else if (high_fault_flag_clear) begin
        high_supervisor_fault_flag <= 1'b0;
      end
      // Reset request is a registered copy of the fault events, gated by the reset enables.
      power_on_reset_req <= (low_fault_ev && low_supervisor_reset_enable) ||
        (high_fault_ev && high_supervisor_reset_enable);
    end
  end

  // I/O float while a side's flag is up and that side's supervisor timer is still settling.
  assign gpio_hiz = (low_supervisor_fault_flag && low_busy) ||
    (high_supervisor_fault_flag && high_busy);

  ////////////////////////////////////////////////////////////////////////////
  // Wakeup masking.

  // Any enabled low side comparator with full performance clear forces slow wakeup.
  assign slow_wakeup = (low_supervisor_state == `SSV_STATE_NORMAL && !deep_sleep) ||
    (low_monitor_state == `SSV_STATE_NORMAL && !deep_sleep) ||
    (low_supervisor_enable && !low_supervisor_full_perf) ||
    (low_monitor_enable && !low_monitor_full_perf);

  // Wake from modes 3 and 4 into a non deep mode.
  wire wake_34;
  assign wake_34 = deep_34_r && !deep_sleep;

  // The wake cycle itself is masked too, so the timer runs one cycle less than the full mask.
  localparam integer WAKE_LONG_I = NORMAL_CYCLES - 1;
  localparam integer WAKE_SHORT_I = FULL_CYCLES - 1;

  // Mask length: long for slow wakeup, short otherwise.
  wire [CNT_W-1:0] wake_load;
  assign wake_load = slow_wakeup ? WAKE_LONG_I[CNT_W-1:0] : WAKE_SHORT_I[CNT_W-1:0];

  wire wake_busy;

  settle_timer #(.CNT_W(CNT_W)) u_wake_timer (
    .clk(clk),
    .rst_b(rst_b),
    .start(wake_34),
    .load_value(wake_load),
    .busy(wake_busy)
  );

  // The CPU is held from the wake cycle until the mask ends.
  assign cpu_exec_mask = wake_34 | wake_busy;

  // The sub-main clock is gated only when it does not come from the oscillator.
  assign sub_main_clock_mask = cpu_exec_mask && !sub_main_clock_from_osc;

endmodule // supply_supervisor_mode_control

/* testbench/power_sequencer_model.sv */
// Purpose: Behavioural low-power sequencer on the far side of the block.
// Assumes: sleep_req is a level from the bench.
// Notes: Deep entry waits until both settle flags have cleared.
`timescale 1ns/1ps
module power_sequencer_model (
  // Clock and reset.
  input logic clk,
  input logic rst_b,
  // Requests and status.
  input logic sleep_req,
  input logic [2:0] deep_mode,
  input logic low_settle_pending_flag,
  input logic high_settle_pending_flag,
  // Mode towards the block.
  output logic [2:0] power_mode
);
  // Entering sleep while a delay runs risks a lost wakeup, so entry is held off.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_mode <= 3'h0;
    end else if (!sleep_req) begin
      power_mode <= 3'h0;
    end else if (!low_settle_pending_flag && !high_settle_pending_flag) begin
      power_mode <= deep_mode;
    end
  end
endmodule // power_sequencer_model

/* testbench/supply_supervisor_properties.sv */
// Purpose: Port-level checks of the supply supervisor mode control.
// Assumes: One clock domain, reset rst_b active low.
// Notes: Mask length is measured with a helper counter.
`timescale 1ns/1ps
module supply_supervisor_checker #(
  parameter int FULL_CYCLES = 80,
  parameter int NORMAL_CYCLES = 6000
) (
  input logic clk,
  input logic rst_b,
  input logic soft_reset,
  input logic low_side_control_write,
  input logic low_supervisor_keep,
  input logic low_supervisor_full_perf,
  input logic low_monitor_enable,
  input logic low_monitor_full_perf,
  input logic low_side_auto_control,
  input logic high_supervisor_keep,
  input logic high_supervisor_full_perf,
  input logic low_supervisor_fault_raw,
  input logic [2:0] power_mode,
  input logic sub_main_clock_from_osc,
  input logic [1:0] low_supervisor_state,
  input logic [1:0] low_monitor_state,
  input logic [1:0] high_supervisor_state,
  input logic low_supervisor_enable,
  input logic high_supervisor_enable,
  input logic low_supervisor_fault_flag,
  input logic high_supervisor_fault_flag,
  input logic low_settle_pending_flag,
  input logic high_settle_pending_flag,
  input logic gpio_hiz,
  input logic slow_wakeup,
  input logic cpu_exec_mask,
  input logic sub_main_clock_mask
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire deep = power_mode >= 3'h2 && power_mode <= 3'h4; // Any deep low-power mode.
  logic [15:0] run_r; // Length of the current mask run.
  // Counts consecutive masked cycles.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_r <= 16'h0000;
    end else begin
      run_r <= cpu_exec_mask ? run_r + 16'h0001 : 16'h0000;
    end
  end
  // Expected comparator state from the configuration table.
  function automatic logic [1:0] st(input logic sup, en, k, f, a, d);
    if (!en) return 2'h0;
    if (!d) return f ? 2'h2 : 2'h1;
    if (a) return (sup ? (k && f) : f) ? 2'h1 : 2'h0;
    if (sup && !k) return 2'h0;
    return f ? 2'h2 : 2'h1;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  property p_low_state;
    $past(rst_b) |-> low_supervisor_state == st(1'b1, low_supervisor_enable, low_supervisor_keep,
      low_supervisor_full_perf, low_side_auto_control, deep) && low_monitor_state == st(1'b0,
      low_monitor_enable, 1'b1, low_monitor_full_perf, low_side_auto_control, deep);
  endproperty
  a_low_state: assert property (p_low_state) else $error("low side state wrong");
  property p_high_off;
    high_supervisor_enable && !high_supervisor_keep && !high_supervisor_full_perf && deep
      |-> high_supervisor_state == 2'h0;
  endproperty
  a_high_off: assert property (p_high_off) else $error("high supervisor not off");
  property p_slow;
    slow_wakeup == (low_supervisor_enable && !low_supervisor_full_perf || low_monitor_enable && !low_monitor_full_perf);
  endproperty
  a_slow: assert property (p_slow) else $error("wakeup speed wrong");
  property p_hiz;
    gpio_hiz == (low_supervisor_fault_flag && low_settle_pending_flag || high_supervisor_fault_flag && high_settle_pending_flag);
  endproperty
  a_hiz: assert property (p_hiz) else $error("io float wrong");
  property p_pend;
    low_side_control_write |=> low_settle_pending_flag [*4];
  endproperty
  a_pend: assert property (p_pend) else $error("no settle delay");
  property p_ignore;
    low_settle_pending_flag && !low_supervisor_fault_flag |=> !low_supervisor_fault_flag;
  endproperty
  a_ignore: assert property (p_ignore) else $error("fault not masked");
  property p_flag;
    low_supervisor_fault_raw && !low_settle_pending_flag && !low_side_control_write && low_supervisor_state != 2'h0
      && $past(low_supervisor_state) != 2'h0 |=> low_supervisor_fault_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("fault flag missed");
  property p_mask;
    $fell(cpu_exec_mask) |-> run_r == (slow_wakeup ? NORMAL_CYCLES : FULL_CYCLES);
  endproperty
  a_mask: assert property (p_mask) else $error("wake mask length wrong");
  property p_osc;
    sub_main_clock_from_osc |-> !sub_main_clock_mask;
  endproperty
  a_osc: assert property (p_osc) else $error("sub clock masked");
  property p_soft;
    soft_reset |=> low_supervisor_enable && high_supervisor_enable;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset kept off");
endmodule // supply_supervisor_checker

/* testbench/tb.sv */
// Purpose: Self-checking bench for the supply supervisor mode control.
// Assumes: Delays shortened to 4 and 20 cycles.
// Notes: The sequencer model drives the power mode.
`timescale 1ns/1ps
module tb;
  localparam int FC = 4; // Shortened full performance delay.
  localparam int NC = 20; // Shortened normal delay.
  logic clk = 1'b0, rst_b = 1'b0, soft_reset = 1'b0, sleep_req = 1'b0, sub_main_clock_from_osc = 1'b0;
  logic low_side_control_write = 1'b0, low_supervisor_enable_in = 1'b1, low_supervisor_keep = 1'b0;
  logic low_supervisor_full_perf = 1'b0, low_monitor_enable = 1'b1, low_monitor_full_perf = 1'b0;
  logic low_side_auto_control = 1'b0, low_supervisor_reset_enable = 1'b1, low_fault_flag_clear = 1'b0;
  logic high_side_control_write = 1'b0, high_supervisor_enable_in = 1'b1, high_supervisor_keep = 1'b0;
  logic high_supervisor_full_perf = 1'b0, high_monitor_enable = 1'b1, high_monitor_full_perf = 1'b0;
  logic high_side_auto_control = 1'b0, high_supervisor_reset_enable = 1'b1, high_fault_flag_clear = 1'b0;
  logic low_supervisor_fault_raw = 1'b0, high_supervisor_fault_raw = 1'b0;
  logic [2:0] deep_mode = 3'h3, power_mode;
  logic [1:0] low_supervisor_state, low_monitor_state, high_supervisor_state, high_monitor_state;
  logic low_supervisor_enable, high_supervisor_enable, low_supervisor_fault_flag, high_supervisor_fault_flag;
  logic low_settle_pending_flag, high_settle_pending_flag, power_on_reset_req, gpio_hiz, slow_wakeup;
  logic cpu_exec_mask, sub_main_clock_mask;
  int err_count = 0, tests_run = 0, c;
  logic por_seen = 1'b0; // Reset request caught in the cycle it stands.
  always #12.5 clk = ~clk;
  supply_supervisor_mode_control #(.FULL_CYCLES(FC), .NORMAL_CYCLES(NC)) supply_supervisor_mode_control_inst (.*);
  power_sequencer_model power_sequencer_model_inst (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected state of an enabled comparator.
  function automatic logic [1:0] es(input logic sup, k, f, a, d);
    if (!d) return f ? 2'h2 : 2'h1;
    if (a) return (sup ? (k && f) : f) ? 2'h1 : 2'h0;
    return (sup && !k) ? 2'h0 : (f ? 2'h2 : 2'h1);
  endfunction
  // Both sides get the same configuration so both are exercised.
  task automatic cfg(input logic k, f, a);
    @(posedge clk);
    low_supervisor_keep <= k;
    high_supervisor_keep <= k;
    low_supervisor_full_perf <= f;
    high_supervisor_full_perf <= f;
    low_monitor_full_perf <= f;
    high_monitor_full_perf <= f;
    low_side_auto_control <= a;
    high_side_auto_control <= a;
  endtask
  task automatic pulse(input int which);
    @(posedge clk);
    {low_side_control_write, high_side_control_write} <= which == 0 ? 2'h3 : 2'h0;
    {low_supervisor_fault_raw, high_supervisor_fault_raw} <= which == 1 ? 2'h3 : 2'h0;
    {low_fault_flag_clear, high_fault_flag_clear} <= which == 2 ? 2'h3 : 2'h0;
    @(posedge clk);
    {low_side_control_write, high_side_control_write} <= 2'h0;
    {low_supervisor_fault_raw, high_supervisor_fault_raw} <= 2'h0;
    {low_fault_flag_clear, high_fault_flag_clear} <= 2'h0;
    @(negedge clk);
    por_seen = power_on_reset_req;
    @(negedge clk);
  endtask
  // Counts cycles with the pending flag (0) or the wake mask (1) high.
  task automatic cnt_hi(input int which, input int win);
    c = 0;
    repeat (win) begin
      @(negedge clk);
      c += which == 0 ? low_settle_pending_flag === 1'b1 : cpu_exec_mask === 1'b1;
    end
  endtask
  task automatic wake(input logic f, input int n);
    cfg(1'b1, f, 1'b0);
    sub_main_clock_from_osc <= !f;
    sleep_req <= 1'b1;
    repeat (4) @(posedge clk);
    chk(power_mode, 3'h3);
    chk(slow_wakeup, !f);
    sleep_req <= 1'b0;
    cnt_hi(1, NC + 6);
    chk(c, n);
  endtask
  task automatic summarize;
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    cnt_hi(0, NC + 4);
    chk({low_supervisor_enable, high_supervisor_enable, low_supervisor_fault_flag, power_on_reset_req}, 4'hC);
    for (int i = 0; i < 16; i++) begin
      cfg(i[0], i[1], i[2]);
      sleep_req <= i[3];
      deep_mode <= 3'h2 + 3'(i % 3);
      repeat (3) @(negedge clk);
      chk(low_supervisor_state, es(1'b1, i[0], i[1], i[2], i[3]));
      chk(low_monitor_state, es(1'b0, i[0], i[1], i[2], i[3]));
    end
    sleep_req <= 1'b0;
    deep_mode <= 3'h3;
    cnt_hi(1, NC + 6);
    low_supervisor_enable_in <= 1'b0;
    high_supervisor_enable_in <= 1'b0;
    pulse(0);
    chk(low_supervisor_state, 2'h0);
    pulse(3);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    @(negedge clk);
    chk({low_supervisor_enable, high_supervisor_enable}, 2'h3);
    cnt_hi(0, NC + 4);
    low_supervisor_enable_in <= 1'b1;
    high_supervisor_enable_in <= 1'b1;
    cfg(1'b1, 1'b0, 1'b0);
    pulse(0);
    cnt_hi(0, NC + 4);
    chk(c, NC - 2);
    cfg(1'b1, 1'b1, 1'b0);
    pulse(0);
    pulse(1);
    chk(low_supervisor_fault_flag, 1'b0);
    cnt_hi(0, NC);
    pulse(1);
    chk({low_supervisor_fault_flag, high_supervisor_fault_flag, por_seen}, 3'h7);
    pulse(0);
    chk(gpio_hiz, 1'b1);
    cnt_hi(0, NC);
    chk(gpio_hiz, 1'b0);
    pulse(2);
    chk(low_supervisor_fault_flag, 1'b0);
    low_supervisor_reset_enable <= 1'b0;
    high_supervisor_reset_enable <= 1'b0;
    pulse(1);
    chk({low_supervisor_fault_flag, por_seen}, 2'h2);
    pulse(2);
    wake(1'b1, FC);
    wake(1'b0, NC);
    summarize;
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    summarize;
  end
endmodule // tb
bind supply_supervisor_mode_control supply_supervisor_checker #(.FULL_CYCLES(FULL_CYCLES),
  .NORMAL_CYCLES(NORMAL_CYCLES)) supply_supervisor_checker_inst (.*);
